/* design/sob_defines.svh */
// Purpose: constants of the shared pixel/control bus
// Assumes: included by the package and the bus module
// Notes:   bit indices of the synchronised pin vector are listed here too
`ifndef SOB_DEFINES_SVH
`define SOB_DEFINES_SVH

`define SOB_W        14
`define SOB_BLSB     6
`define SOB_NREG     8
`define SOB_REG_RST  8'h00
`define SOB_SER_BITS 5'h10
`define SOB_RB_BITS  4'h8
`define SOB_FIFO_D   2'h2
// synchronised pin vector layout
`define SOB_PIN_W    13
`define SOB_P_RSTN   12
`define SOB_P_OEB    11
`define SOB_P_STB    10
`define SOB_P_DNA    9
`define SOB_P_SCK    8

`endif

/* design/sob_pkg.sv */
// Purpose: types of the shared pixel/control bus
// Assumes: sob_defines.svh gives the widths
// Notes:   phase codes are gray along the 4-transfer path
`include "sob_defines.svh"
package sob_pkg;
    typedef enum logic [1:0] {
        SOB_FMT_14 = 2'h0,
        SOB_FMT_8  = 2'h1,
        SOB_FMT_7  = 2'h2,
        SOB_FMT_4  = 2'h3
    } sob_fmt_t;

    typedef enum logic [1:0] {
        SOB_PH0 = 2'h0,
        SOB_PH1 = 2'h1,
        SOB_PH2 = 2'h3,
        SOB_PH3 = 2'h2
    } sob_ph_t;

    typedef struct packed {
        logic [`SOB_PIN_W-1:0]           sync1;
        logic [`SOB_PIN_W-1:0]           sync2;
        logic [`SOB_PIN_W-1:0]           prev;
        logic                            par_mode;
        logic [`SOB_NREG-1:0][7:0]       regs;
        logic [7:0]                      addr;
        logic [15:0]                     ser_sh;
        logic [4:0]                      ser_cnt;
        logic [7:0]                      rb_sh;
        logic [3:0]                      rb_cnt;
        logic [1:0][`SOB_W-1:0]          fifo;
        logic                            wr_ptr;
        logic                            rd_ptr;
        logic [1:0]                      cnt;
        logic                            busy;
        sob_ph_t                         phase;
        logic [`SOB_W-1:0]               cur;
        logic [`SOB_W-1:0]               pix;
        logic                            pix_vld;
        logic [`SOB_W-1:0]               bus;
        logic [`SOB_W-1:0]               oe;
    } sob_state_t;
endpackage

/* design/sob_bus.sv */
// Purpose: shared 14-line pixel output and control bus of the digitiser
// Assumes: conversion words arrive on clk_sys_i; pins are asynchronous
// Notes:   pins pass two flops, so the bus reacts three cycles after a pin edge
`timescale 1ns/1ps
`include "sob_defines.svh"

// Contract
// [RQ1] output disable releases all fourteen lines
// [RQ2] 14-bit format: whole result at once
// [RQ3] 8-bit format: upper eight lines, two transfers
// [RQ4] 7-bit format: upper lines, two transfers
// [RQ5] 4-bit format: top four lines, four transfers
// [RQ6] parallel write: controller drives upper byte
// [RQ7] parallel read: device drives read-back byte
// [RQ8] serial read-back shifts out on top line
// [RQ9] reset input restores default register contents
// [RQ10] reset input selects serial or parallel control
// [RQ11] strobe level at reset release picks mode
// [RQ12] controller marks data high, address low
// [RQ13] strobe active low, serial enable active high
// [RQ14] multiplexed formats send most significant part first
module sob_bus (
    // clock, reset, enable
    input  wire logic                        clk_sys_i,
    input  wire logic                        srst_i,
    input  wire logic                        ce_i,
    // control pins
    input  wire logic                        reset_n_in_i,
    input  wire logic                        output_disable_in_i,
    input  wire logic                        enable_or_strobe_in_i,
    input  wire logic                        serial_in_or_data_addr_sel_i,
    input  wire logic                        serial_clk_or_direction_sel_i,
    // shared bus, three-signal form
    input  wire logic [`SOB_W-1:0]           shared_pixel_bus_i,
    output wire logic [`SOB_W-1:0]           shared_pixel_bus_o,
    output wire logic [`SOB_W-1:0]           shared_pixel_bus_oe_o,
    // conversion stream
    input  wire sob_pkg::sob_fmt_t           fmt_i,
    input  wire logic                        conv_valid_i,
    output wire logic                        conv_ready_o,
    input  wire logic [`SOB_W-1:0]           conv_data_i,
    // status towards the core
    output wire logic                        pix_valid_o,
    output wire logic                        par_mode_o,
    output wire logic [`SOB_NREG*8-1:0]      ctrl_regs_o
);
    import sob_pkg::*;

    sob_state_t q;
    sob_state_t d;
    logic       stall;
    logic       push;
    logic       pop;
    logic       last_now;

    function automatic logic is_last(sob_fmt_t f, sob_ph_t p);
        unique case (f)
            SOB_FMT_14: is_last = 1'b1;
            SOB_FMT_8,
            SOB_FMT_7:  is_last = (p == SOB_PH1);
            SOB_FMT_4:  is_last = (p == SOB_PH3);
        endcase
    endfunction

    function automatic sob_ph_t ph_next(sob_ph_t p);
        unique case (p)
            SOB_PH0: ph_next = SOB_PH1;
            SOB_PH1: ph_next = SOB_PH2;
            SOB_PH2: ph_next = SOB_PH3;
            SOB_PH3: ph_next = SOB_PH0;
        endcase
    endfunction

    // bus image of one transfer; most significant part always goes first
    function automatic logic [`SOB_W-1:0] slice(sob_fmt_t f, logic [`SOB_W-1:0] w,
                                                 sob_ph_t p);
        slice = '0;
        unique case (f)
            SOB_FMT_14: slice = w;
            SOB_FMT_8:  slice = (p == SOB_PH0) ? {w[13:6], 6'h00} : {w[5:0], 8'h00};
            SOB_FMT_7:  slice = (p == SOB_PH0) ? {w[13:7], 7'h00} : {w[6:0], 7'h00};
            SOB_FMT_4: begin
                unique case (p)
                    SOB_PH0: slice = {w[13:10], 10'h000};
                    SOB_PH1: slice = {w[9:6], 10'h000};
                    SOB_PH2: slice = {w[5:2], 10'h000};
                    SOB_PH3: slice = {w[1:0], 12'h000};
                endcase
            end
        endcase
    endfunction

    function automatic logic rise(sob_state_t s, int b);
        rise = s.sync2[b] & ~s.prev[b];
    endfunction

    // a parallel access owns the upper lines, so pixel output waits
    assign stall    = q.par_mode & ~q.sync2[`SOB_P_STB];
    assign last_now = is_last(fmt_i, q.phase);
    assign push     = ce_i & conv_valid_i & (q.cnt != `SOB_FIFO_D);
    assign pop      = ce_i & ~stall & (q.cnt != 2'h0) & (~q.busy | last_now);

    always_comb begin
        d = q;
        d.sync1 = {reset_n_in_i, output_disable_in_i, enable_or_strobe_in_i,
                   serial_in_or_data_addr_sel_i, serial_clk_or_direction_sel_i,
                   shared_pixel_bus_i[13:6]};
        d.sync2 = q.sync1;
        d.prev  = q.sync2;

        // two-entry buffer
        if (push) begin
            d.fifo[q.wr_ptr] = conv_data_i;
            d.wr_ptr         = ~q.wr_ptr;
        end
        if (pop) begin
            d.rd_ptr = ~q.rd_ptr;
        end
        unique case ({push, pop})
            2'b10:   d.cnt = q.cnt + 2'h1;
            2'b01:   d.cnt = q.cnt - 2'h1;
            default: d.cnt = q.cnt;
        endcase

        // [RQ14] msb part first
        if (stall) begin
            d.pix_vld = 1'b0;
        end else if (pop) begin
            // [RQ2] full word per sample
            d.cur     = q.fifo[q.rd_ptr];
            d.busy    = 1'b1;
            d.phase   = SOB_PH0;
            d.pix     = slice(fmt_i, q.fifo[q.rd_ptr], SOB_PH0);
            d.pix_vld = 1'b1;
        end else if (q.busy && !last_now) begin
            // [RQ3] [RQ4] [RQ5] further transfers
            d.phase   = ph_next(q.phase);
            d.pix     = slice(fmt_i, q.cur, ph_next(q.phase));
            d.pix_vld = 1'b1;
        end else begin
            d.busy    = 1'b0;
            d.pix_vld = 1'b0;
        end

        if (!q.sync2[`SOB_P_RSTN]) begin
            // [RQ9] defaults while held
            d.regs    = {`SOB_NREG{`SOB_REG_RST}};
            d.addr    = 8'h00;
            d.rb_cnt  = 4'h0;
            d.ser_cnt = 5'h00;
        end else if (rise(q, `SOB_P_RSTN)) begin
            // [RQ10] [RQ11] latch interface choice
            d.par_mode = q.sync2[`SOB_P_STB];
        end else if (q.par_mode) begin
            // [RQ6] [RQ12] write at strobe end
            if (rise(q, `SOB_P_STB) && !q.sync2[`SOB_P_SCK]) begin
                if (q.sync2[`SOB_P_DNA]) begin
                    d.regs[q.addr[2:0]] = q.sync2[7:0];
                end else begin
                    d.addr = q.sync2[7:0];
                end
            end
        end else begin
            if (rise(q, `SOB_P_SCK)) begin
                d.ser_sh = {q.ser_sh[14:0], q.sync2[`SOB_P_DNA]};
                if (q.ser_cnt != `SOB_SER_BITS) begin
                    d.ser_cnt = q.ser_cnt + 5'h01;
                end
                if (q.rb_cnt != 4'h0) begin
                    d.rb_sh  = {q.rb_sh[6:0], 1'b0};
                    d.rb_cnt = q.rb_cnt - 4'h1;
                end
            end
            // [RQ13] enable pulse ends a frame
            if (rise(q, `SOB_P_STB)) begin
                if (q.ser_cnt == `SOB_SER_BITS) begin
                    d.regs[q.ser_sh[10:8]] = q.ser_sh[7:0];
                end
                d.addr    = q.ser_sh[15:8];
                d.rb_sh   = q.regs[q.ser_sh[10:8]];
                d.rb_cnt  = `SOB_RB_BITS;
                d.ser_cnt = 5'h00;
            end
        end

        // pin drive, registered
        d.bus = q.pix;
        d.oe  = {`SOB_W{1'b1}};
        if (stall) begin
            // [RQ7] read-back on upper byte
            d.bus[13:6] = q.regs[q.addr[2:0]];
            // [RQ6] release upper byte
            d.oe[13:6]  = {8{q.sync2[`SOB_P_SCK]}};
        end
        if (!q.par_mode && q.rb_cnt != 4'h0) begin
            // [RQ8] serial read-back on line 13
            d.bus[13] = q.rb_sh[7];
        end
        if (q.sync2[`SOB_P_OEB]) begin
            // [RQ1] all lines released
            d.oe = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            q          <= '0;
            q.par_mode <= 1'b1;
            q.phase    <= SOB_PH0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign shared_pixel_bus_o    = q.bus;
    assign shared_pixel_bus_oe_o = q.oe;
    assign conv_ready_o          = (q.cnt != `SOB_FIFO_D);
    assign pix_valid_o           = q.pix_vld;
    assign par_mode_o            = q.par_mode;
    assign ctrl_regs_o           = q.regs;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    property p_hiz;
        ce_i && q.sync2[`SOB_P_OEB] |=> shared_pixel_bus_oe_o == '0;
    endproperty
    a_hiz: assert property (p_hiz) else $error("bus not released"); // [RQ1]

    property p_full;
        pop && fmt_i == SOB_FMT_14 |=> q.pix == $past(q.fifo[q.rd_ptr]) && q.pix_vld;
    endproperty
    a_full: assert property (p_full) else $error("14-bit word wrong"); // [RQ2]

    property p_fmt8;
        pop && fmt_i == SOB_FMT_8 |=> q.pix[13:6] == $past(q.fifo[q.rd_ptr][13:6]);
    endproperty
    a_fmt8: assert property (p_fmt8) else $error("8-bit first part wrong"); // [RQ3]

    property p_fmt7;
        pop && fmt_i == SOB_FMT_7 |=> q.pix[13:7] == $past(q.fifo[q.rd_ptr][13:7]);
    endproperty
    a_fmt7: assert property (p_fmt7) else $error("7-bit first part wrong"); // [RQ4]

    property p_fmt4;
        pop && fmt_i == SOB_FMT_4
            |=> q.pix[13:10] == $past(q.fifo[q.rd_ptr][13:10]) && q.phase == SOB_PH0;
    endproperty
    a_fmt4: assert property (p_fmt4) else $error("4-bit first part wrong"); // [RQ5]

    property p_second;
        ce_i && !stall && q.busy && q.phase == SOB_PH0 && fmt_i == SOB_FMT_8
            |=> q.pix[13:8] == $past(q.cur[5:0]) && q.phase == SOB_PH1;
    endproperty
    a_second: assert property (p_second) else $error("low part order wrong"); // [RQ14]

    property p_pwr;
        ce_i && stall && !q.sync2[`SOB_P_SCK] && !q.sync2[`SOB_P_OEB]
            |=> shared_pixel_bus_oe_o[13:6] == 8'h00;
    endproperty
    a_pwr: assert property (p_pwr) else $error("upper byte driven on write"); // [RQ6]

    property p_prd;
        ce_i && stall && q.sync2[`SOB_P_SCK] && !q.sync2[`SOB_P_OEB]
            |=> shared_pixel_bus_oe_o[13:6] == 8'hff
                && shared_pixel_bus_o[13:6] == $past(q.regs[q.addr[2:0]]);
    endproperty
    a_prd: assert property (p_prd) else $error("read-back byte wrong"); // [RQ7]

    property p_ser;
        ce_i && !q.par_mode && q.rb_cnt != 4'h0 && !q.sync2[`SOB_P_OEB]
            |=> shared_pixel_bus_o[13] == $past(q.rb_sh[7]) && shared_pixel_bus_oe_o[13];
    endproperty
    a_ser: assert property (p_ser) else $error("serial bit wrong"); // [RQ8]

    property p_rst;
        ce_i && !q.sync2[`SOB_P_RSTN] |=> q.regs == '0 && q.rb_cnt == 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("registers not defaulted"); // [RQ9]

    property p_mode;
        ce_i && rise(q, `SOB_P_RSTN) |=> q.par_mode == $past(q.sync2[`SOB_P_STB]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not latched"); // [RQ11]

    c_fmt4: cover property (pop && fmt_i == SOB_FMT_4 ##1 q.busy [*3]);
    c_full: cover property (q.cnt == `SOB_FIFO_D && !conv_ready_o);
    c_pwr:  cover property (ce_i && q.par_mode && rise(q, `SOB_P_STB));
    c_ser:  cover property (!q.par_mode && q.rb_cnt == `SOB_RB_BITS);
endmodule

/* tb/sob_ctl_model.sv */
// Purpose: scanner controller model on the control pins of the bus
// Assumes: pins move just after a rising edge and hold 4+ cycles
// Notes:   a released line reads the inverse of its last level, never a pull
`timescale 1ns/1ps
module sob_ctl_model (
    // clock
    input  wire logic        clk_i,
    // device drive
    input  wire logic [13:0] dev_bus_i,
    input  wire logic [13:0] dev_oe_i,
    // pins
    output logic             rstn_o,
    output logic             oeb_o,
    output logic             stb_o,
    output logic             dna_o,
    output logic             dir_o,
    output logic [13:0]      lvl_o
);
    logic        par_q = 1'b1;
    logic        drv_q = 1'b0;
    logic [7:0]  byte_q = 8'h00;
    logic [13:0] last = 14'h0000;
    logic [13:0] wm;
    initial begin
        rstn_o = 1'b0;
        oeb_o = 1'b0;
        stb_o = 1'b1;
        dna_o = 1'b0;
        dir_o = 1'b0;
    end
    assign wm = (par_q && drv_q) ? 14'h3fc0 : 14'h0000;
    assign lvl_o = (dev_oe_i & dev_bus_i) | (~dev_oe_i & wm & {byte_q, 6'h00})
                 | (~dev_oe_i & ~wm & ~last);
    always @(posedge clk_i) last <= lvl_o;
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // strobe level at reset rise picks mode
    // serial clock parked low so the first frame bit gives a rising edge
    task automatic reset_pin(input logic par);
        rstn_o <= 1'b0;
        stb_o <= par;
        dir_o <= 1'b0;
        wait_n(6);
        rstn_o <= 1'b1;
        wait_n(6);
        par_q <= par;
    endtask
    task automatic set_oeb(input logic b);
        oeb_o <= b;
        wait_n(5);
    endtask
    // data high, address low, strobe low
    task automatic par_open(input logic rd, input logic dat, input logic [7:0] b);
        dir_o <= rd;
        dna_o <= dat;
        byte_q <= b;
        drv_q <= !rd;
        wait_n(1);
        stb_o <= 1'b0;
        wait_n(5);
    endtask
    // byte held a little past the strobe rise
    task automatic par_close();
        stb_o <= 1'b1;
        wait_n(2);
        drv_q <= 1'b0;
        wait_n(3);
    endtask
    // serial clock and high enable pulse
    task automatic ser_bit(input logic b);
        dna_o <= b;
        wait_n(4);
        dir_o <= 1'b1;
        wait_n(4);
        dir_o <= 1'b0;
        wait_n(4);
    endtask
    task automatic ser_frame(input logic [15:0] f);
        for (int i = 15; i >= 0; i--) ser_bit(f[i]);
        stb_o <= 1'b1;
        wait_n(4);
        stb_o <= 1'b0;
        wait_n(4);
    endtask
endmodule

/* tb/sob_bus_tb.sv */
// Purpose: self-checking bench of the shared pixel/control bus
// Assumes: design sources compiled first
// Notes:   expectations come from the transfer layout, never from outputs
`timescale 1ns/1ps
module sob_bus_tb;
    import sob_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic        rand_ce = 1'b0;
    sob_fmt_t    fmt = SOB_FMT_14;
    logic        cv = 1'b0;
    logic [13:0] cd = 14'h0000;
    logic        cr, pv, pm;
    logic        pv_q = 1'b0;
    logic [63:0] regs;
    logic [13:0] bus_o, oe, lvl;
    logic        rstn, output_disable_in, stb, dna, dir;
    logic [13:0] exp_q[$];
    int          fail_count = 0;
    int          n_compared = 0;

    initial begin
        forever #2.5 clk = ~clk;
    end

    sob_bus DUT (.clk_sys_i(clk), .srst_i(srst), .ce_i(ce), .reset_n_in_i(rstn),
        .output_disable_in_i(output_disable_in), .enable_or_strobe_in_i(stb),
        .serial_in_or_data_addr_sel_i(dna), .serial_clk_or_direction_sel_i(dir),
        .shared_pixel_bus_i(lvl), .shared_pixel_bus_o(bus_o), .shared_pixel_bus_oe_o(oe),
        .fmt_i(fmt), .conv_valid_i(cv), .conv_ready_o(cr), .conv_data_i(cd),
        .pix_valid_o(pv), .par_mode_o(pm), .ctrl_regs_o(regs));

    sob_ctl_model u_ctl (.clk_i(clk), .dev_bus_i(bus_o), .dev_oe_i(oe), .rstn_o(rstn),
        .oeb_o(output_disable_in), .stb_o(stb), .dna_o(dna), .dir_o(dir), .lvl_o(lvl));

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    function automatic int nparts(input sob_fmt_t f);
        return (f == SOB_FMT_14) ? 1 : (f == SOB_FMT_4) ? 4 : 2;
    endfunction

    // bus image of transfer k of word w; unused lines read 0
    function automatic logic [13:0] part(input sob_fmt_t f, input logic [13:0] w, input int k);
        logic [15:0] s;
        s = {w, 2'b00};
        case (f)
            SOB_FMT_8: part = {s[15-8*k -: 8], 6'h00};
            SOB_FMT_7: part = {w[13-7*k -: 7], 7'h00};
            SOB_FMT_4: part = {s[15-4*k -: 4], 10'h000};
            default:   part = w;
        endcase
    endfunction

    // valid stays up between back-to-back words; the caller drops it
    task automatic send(input logic [13:0] w);
        cv <= 1'b1;
        cd <= w;
        for (int k = 0; k < nparts(fmt); k++) exp_q.push_back(part(fmt, w, k));
        do @(posedge clk); while (!(cr === 1'b1 && ce === 1'b1));
    endtask

    task automatic settle();
        cv <= 1'b0;
        repeat (40) @(posedge clk);
        check(exp_q.size(), 0);
    endtask

    task automatic rb(input logic [7:0] e);
        for (int i = 7; i >= 0; i--) begin
            check({oe[13], bus_o[13]}, {1'b1, e[i]});
            u_ctl.ser_bit(1'b0);
        end
    endtask

    // each transfer shows on the bus one edge after its valid cycle
    always @(posedge clk) begin
        ce <= rand_ce ? ($urandom % 8 != 0) : 1'b1;
        pv_q <= pv & ce;
        if (pv_q) begin
            if (exp_q.size() == 0) check(1'b1, 1'b0);
            else check(bus_o, exp_q.pop_front());
        end
    end

    initial begin
        #50000;
        fail_count++;
        test_done();
    end

    initial begin
        void'($urandom(30122));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        u_ctl.reset_pin(1'b1);
        check(pm, 1'b1);
        check(regs, 64'h0);
        rand_ce <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            fmt <= sob_fmt_t'(f);
            @(posedge clk);
            send(14'h3fff);
            send(14'h0000);
            repeat (6) send(14'($urandom));
            settle();
        end
        rand_ce <= 1'b0;
        u_ctl.par_open(1'b0, 1'b0, 8'h05);
        u_ctl.par_close();
        u_ctl.par_open(1'b0, 1'b1, 8'ha7);
        check(oe[13:6], 8'h00);
        u_ctl.par_close();
        check(regs, 64'h0000a700_00000000);
        u_ctl.par_open(1'b1, 1'b1, 8'h00);
        check({oe[13:6], bus_o[13:6]}, 16'hffa7);
        // read access holds pops off, so the buffer must fill and refuse
        send(14'h2c35);
        send(14'h1ac3);
        cv <= 1'b0;
        repeat (4) @(posedge clk);
        check({cr, pv}, 2'b00);
        check({oe[13:6], bus_o[13:6]}, 16'hffa7);
        u_ctl.par_close();
        settle();
        u_ctl.set_oeb(1'b1);
        check(oe, 14'h0000);
        u_ctl.par_open(1'b1, 1'b1, 8'h00);
        check(oe, 14'h0000);
        u_ctl.par_close();
        u_ctl.set_oeb(1'b0);
        u_ctl.reset_pin(1'b0);
        check(pm, 1'b0);
        check(regs, 64'h0);
        u_ctl.ser_frame({8'h03, 8'h5c});
        rb(8'h00);
        check(regs, 64'h00000000_5c000000);
        u_ctl.ser_frame({8'h03, 8'h11});
        rb(8'h5c);
        check(regs, 64'h00000000_11000000);
        test_done();
    end
endmodule
